// [dtx_pkg.sv]
// constants and code tables shared by the tone transceiver control logic
package dtx_pkg;
	// clock and sampling
	localparam int CLK_MHZ = 25;
	localparam int SAMPLE_US = 1000;
	localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
	localparam int TICK_MS = SAMPLE_US / 1000;
	// receiver tone and pause qualification, in ms
	localparam int RX_ON_MS = 40;
	localparam int RX_OFF_MS = 40;
	localparam logic [5:0] RX_ON_TICKS = 6'((RX_ON_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [5:0] RX_OFF_TICKS = 6'((RX_OFF_MS + TICK_MS - 1) / TICK_MS);
	// call progress qualification, in ms
	localparam int CP_ON_MS = 40;
	localparam int CP_OFF_MS = 40;
	localparam logic [5:0] CP_ON_TICKS = 6'((CP_ON_MS + TICK_MS - 1) / TICK_MS);
	localparam logic [5:0] CP_OFF_TICKS = 6'((CP_OFF_MS + TICK_MS - 1) / TICK_MS);
	// digit codes outside the plain binary range
	localparam logic [3:0] CODE_ZERO = 4'hA;
	localparam logic [3:0] CODE_STAR = 4'hB;
	localparam logic [3:0] CODE_HASH = 4'hC;
	localparam logic [3:0] CODE_A = 4'hD;
	localparam logic [3:0] CODE_B = 4'hE;
	localparam logic [3:0] CODE_C = 4'hF;
	localparam logic [3:0] CODE_D = 4'h0;
	// tone frequencies in Hz, row then column group
	localparam logic [10:0] ROW_HZ [4] = '{11'd697, 11'd770, 11'd852, 11'd941};
	localparam logic [10:0] COL_HZ [4] = '{11'd1209, 11'd1336, 11'd1477, 11'd1633};
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
	// control fields and reset value
	localparam int CTRL_RX_EN = 0;
	localparam int CTRL_CP_EN = 1;
	localparam logic [1:0] CTRL_RST = 2'h3;
	// status fields
	localparam int ST_CODE = 0;
	localparam int ST_VALID = 4;
	localparam int ST_EARLY = 5;
	localparam int ST_CP = 6;
	localparam int ST_TONE = 7;
	localparam int ST_GEN = 8;
	// interrupt bits
	localparam int IRQ_DIGIT = 0;
	localparam int IRQ_PAUSE = 1;
	localparam int IRQ_CP_ON = 2;
	localparam int IRQ_CP_OFF = 3;
	localparam int IRQ_EARLY = 4;
	localparam int IRQ_W = 5;
	localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
endpackage

// [dtx_qual.sv]
// duration qualifier: a level flips only after the sense persists for a set number of ticks
`timescale 1ns/1ps
module dtx_qual #(
	parameter logic [5:0] ON_TICKS = 6'd40,
	parameter logic [5:0] OFF_TICKS = 6'd40
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// sampling
	input wire logic tick,
	input wire logic sense,
	input wire logic restart,
	// qualified state
	output logic level_q,
	output logic rise_q,
	output logic fall_q
);
	logic [5:0] count_q;
	logic [5:0] need;

	assign need = level_q ? OFF_TICKS : ON_TICKS;

	// short bursts and short gaps never reach the threshold, so they are bridged
	always_ff @(posedge ref_clk)
	begin
		if (rst || restart || sense == level_q)
			count_q <= '0;
		else if (tick)
			count_q <= count_q + 6'd1;
	end

	always_ff @(posedge ref_clk)
	begin
		rise_q <= 1'b0;
		fall_q <= 1'b0;
		if (rst)
			level_q <= 1'b0;
		else if (tick && !restart && sense != level_q && count_q == need - 6'd1)
		begin
			level_q <= sense;
			rise_q <= sense;
			fall_q <= !sense;
		end
	end

	flip_count_a: assert property (@(posedge ref_clk) disable iff (rst) // [RQ8]
		$changed(level_q) |-> $past(count_q) == $past(need) - 6'd1)
		else $error("level changed before its duration was reached");
	pulse_level_a: assert property (@(posedge ref_clk) disable iff (rst) // [RQ11]
		(rise_q |-> level_q) and (fall_q |-> !level_q))
		else $error("edge pulse disagrees with level");
endmodule

// [dtx_transceiver.sv]
// tone transceiver control: receiver qualifier, generator latch, call progress, bus slave
//
// Summary of operation
// [RQ1] early flag rises when a tone pair appears, falls when it goes
// [RQ2] receive code is only trusted while digit valid is high
// [RQ3] host places the four-bit code to send on the generator pins
// [RQ4] falling edge of the latch strobe stores the code and starts tones
// [RQ5] generator reset silences output until a new code is latched
// [RQ6] generator codes use the receiver encoding, hash C, A-C D-F, D zero
// [RQ7] each digit selects one row and one column tone of the matrix
// [RQ8] a pair lasting 40 ms is a digit, 20 ms bursts are rejected
// [RQ9] a 40 ms pause ends the digit, 20 ms dropouts are bridged
// [RQ10] call progress reports signals of 40 ms, never those of 10 ms
// [RQ11] call progress reports silence after 40 ms, ignores 20 ms gaps
// [RQ12] call progress output follows the signal's on and off cadence
// [RQ13] receive code pins are driven only while output enable is low
// [RQ14] code and digit valid clear once a valid pause is timed
// [RQ15] digits 1-9 binary, 0 is 1010, star is 1011, bit 3 highest
// [RQ16] band indications are sampled on a periodic tick from the clock
// [RQ17] code is loaded one cycle before digit valid rises
`timescale 1ns/1ps
module dtx_transceiver
#(
	parameter int SAMPLE_CYCLES = dtx_pkg::SAMPLE_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// band detector indications, one per tone
	input wire logic [3:0] row_tone,
	input wire logic [3:0] col_tone,
	input wire logic cp_energy,
	// receiver output enable and outputs
	input wire logic rx_output_enable_n,
	output logic [3:0] rx_code,
	output logic rx_code_oe,
	output logic digit_valid,
	output logic early_tone_flag,
	// generator pins
	input wire logic [3:0] tx_code,
	input wire logic tx_latch,
	input wire logic tx_reset,
	output logic tone_enable,
	output logic [10:0] row_hz,
	output logic [10:0] col_hz,
	// call progress
	output logic call_progress_out,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// interrupt
	output logic irq
);
	import dtx_pkg::*;
	function automatic logic [3:0] code_to_rc(input logic [3:0] c); // row in [3:2], col in [1:0]
		case (c)
			4'h1: code_to_rc = 4'b0000;
			4'h2: code_to_rc = 4'b0001;
			4'h3: code_to_rc = 4'b0010;
			4'h4: code_to_rc = 4'b0100;
			4'h5: code_to_rc = 4'b0101;
			4'h6: code_to_rc = 4'b0110;
			4'h7: code_to_rc = 4'b1000;
			4'h8: code_to_rc = 4'b1001;
			4'h9: code_to_rc = 4'b1010;
			CODE_ZERO: code_to_rc = 4'b1101;
			CODE_STAR: code_to_rc = 4'b1100;
			CODE_HASH: code_to_rc = 4'b1110;
			CODE_A: code_to_rc = 4'b0011;
			CODE_B: code_to_rc = 4'b0111;
			CODE_C: code_to_rc = 4'b1011;
			default: code_to_rc = 4'b1111;
		endcase
	endfunction

	function automatic logic [3:0] rc_to_code(input logic [3:0] rc);
		rc_to_code = CODE_D;
		for (int i = 0; i < 16; i++)
			if (code_to_rc(4'(i)) == rc)
				rc_to_code = 4'(i);
	endfunction

	function automatic logic [1:0] hot_idx(input logic [3:0] v);
		hot_idx = 2'd0;
		for (int i = 0; i < 4; i++)
			if (v[i])
				hot_idx = 2'(i);
	endfunction

	// two-flop synchronisers for every pin input
	localparam int SW = 16;
	logic [SW-1:0] meta_q;
	logic [SW-1:0] sync_q;
	always_ff @(posedge ref_clk)
	begin
		meta_q <= {row_tone, col_tone, cp_energy, tx_code, tx_latch, tx_reset, rx_output_enable_n};
		sync_q <= meta_q;
	end
	logic [3:0] row_s, col_s, tx_code_s;
	logic cp_s, latch_s, gen_rst_s, oe_n_s;
	assign {row_s, col_s, cp_s, tx_code_s, latch_s, gen_rst_s, oe_n_s} = sync_q;

	// registers
	logic [1:0] ctrl_q;
	logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;

	// sampling tick
	logic [15:0] tick_cnt_q;
	logic tick_q;
	always_ff @(posedge ref_clk)
	begin
		if (rst || tick_cnt_q == 16'(SAMPLE_CYCLES - 1))
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + 16'd1;
		tick_q <= !rst && tick_cnt_q == 16'(SAMPLE_CYCLES - 1); // [RQ16]
	end

	// receiver: a pair is exactly one row and one column tone
	logic pair_now;
	logic [3:0] code_now, cand_q;
	logic tone_lvl, tone_rise, tone_fall, load_q;
	assign pair_now = ctrl_q[CTRL_RX_EN] && $onehot(row_s) && $onehot(col_s);
	assign code_now = rc_to_code({hot_idx(row_s), hot_idx(col_s)}); // [RQ15]

	// a change of digit before the pair is qualified restarts the tone timing
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			cand_q <= CODE_D;
		else if (tick_q && pair_now)
			cand_q <= code_now;
	end

	dtx_qual #(.ON_TICKS(RX_ON_TICKS), .OFF_TICKS(RX_OFF_TICKS)) u_tone_qual ( // [RQ8] [RQ9]
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick_q),
		.sense(pair_now),
		.restart(tick_q && pair_now && !tone_lvl && code_now != cand_q),
		.level_q(tone_lvl),
		.rise_q(tone_rise),
		.fall_q(tone_fall)
	);

	always_ff @(posedge ref_clk)
	begin
		if (rst || tone_fall)
		begin
			rx_code <= '0; // [RQ14]
			load_q <= 1'b0;
			digit_valid <= 1'b0;
		end
		else
		begin
			if (tone_rise)
				rx_code <= cand_q; // [RQ17]
			load_q <= tone_rise;
			if (load_q)
				digit_valid <= 1'b1; // [RQ2]
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			early_tone_flag <= 1'b0;
		else if (tick_q)
			early_tone_flag <= pair_now; // [RQ1]
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
			rx_code_oe <= 1'b0;
		else
			rx_code_oe <= !oe_n_s; // [RQ13]
	end

	// generator
	logic latch_prev_q, latch_fall;
	logic [3:0] gen_code_q;
	logic [3:0] gen_rc;
	assign latch_fall = latch_prev_q && !latch_s;
	assign gen_rc = code_to_rc(tx_code_s); // [RQ6]
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			latch_prev_q <= 1'b0;
			gen_code_q <= CODE_D;
			tone_enable <= 1'b0;
			row_hz <= '0;
			col_hz <= '0;
		end
		else
		begin
			latch_prev_q <= latch_s;
			if (gen_rst_s)
				tone_enable <= 1'b0; // [RQ5]
			else if (latch_fall)
			begin
				gen_code_q <= tx_code_s; // [RQ3] [RQ4]
				tone_enable <= 1'b1;
				row_hz <= ROW_HZ[gen_rc[3:2]]; // [RQ7]
				col_hz <= COL_HZ[gen_rc[1:0]];
			end
		end
	end

	// call progress
	logic cp_rise, cp_fall, cp_lvl;
	dtx_qual #(.ON_TICKS(CP_ON_TICKS), .OFF_TICKS(CP_OFF_TICKS)) u_cp_qual ( // [RQ10] [RQ11]
		.ref_clk(ref_clk),
		.rst(rst),
		.tick(tick_q),
		.sense(cp_s && ctrl_q[CTRL_CP_EN]),
		.restart(1'b0),
		.level_q(cp_lvl),
		.rise_q(cp_rise),
		.fall_q(cp_fall)
	);
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			call_progress_out <= 1'b0;
		else
			call_progress_out <= cp_lvl; // [RQ12]
	end

	// ahb-lite slave, zero wait states, read data latched in the address phase
	logic take;
	logic wr_pend_q;
	logic [7:0] wr_addr_q;
	logic [31:0] rd_mux;
	assign take = hsel && htrans[1] && hready;
	always_comb
	begin
		rd_mux = '0;
		case (haddr[7:0])
			REG_CTRL: rd_mux[1:0] = ctrl_q;
			REG_STATUS:
			begin
				rd_mux[ST_CODE+:4] = rx_code;
				rd_mux[ST_VALID] = digit_valid;
				rd_mux[ST_EARLY] = early_tone_flag;
				rd_mux[ST_CP] = call_progress_out;
				rd_mux[ST_TONE] = tone_enable;
				rd_mux[ST_GEN+:4] = gen_code_q;
			end
			REG_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_q;
			REG_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_q;
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata <= '0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_q <= take && hwrite;
			if (take)
				wr_addr_q <= haddr[7:0];
			if (take && !hwrite)
				hrdata <= rd_mux;
		end
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RST;
			irq_mask_q <= IRQ_RST;
		end
		else if (wr_pend_q)
		begin
			if (wr_addr_q == REG_CTRL)
				ctrl_q <= hwdata[1:0];
			if (wr_addr_q == REG_IRQ_MASK)
				irq_mask_q <= hwdata[IRQ_W-1:0];
		end
	end

	// sticky events: a set in the clearing cycle survives
	assign irq_ev = {!early_tone_flag && tick_q && pair_now, cp_fall, cp_rise, tone_fall, load_q};
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			irq_stat_q <= IRQ_RST;
		else if (wr_pend_q && wr_addr_q == REG_IRQ_STAT)
			irq_stat_q <= (irq_stat_q & ~hwdata[IRQ_W-1:0]) | irq_ev;
		else
			irq_stat_q <= irq_stat_q | irq_ev;
	end
	always_ff @(posedge ref_clk)
	begin
		if (rst)
			irq <= 1'b0;
		else
			irq <= |(irq_stat_q & irq_mask_q);
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	sequence digit_declared;
		tone_rise ##1 load_q;
	endsequence
	code_before_valid_a: assert property (digit_declared |=> digit_valid && $stable(rx_code)) // [RQ17]
		else $error("code not settled when digit valid rose");
	pause_clears_a: assert property (tone_fall |=> !digit_valid && rx_code == 4'h0) // [RQ14]
		else $error("pause did not clear code and valid");
	early_follow_a: assert property (tick_q |=> early_tone_flag == $past(pair_now)) // [RQ1]
		else $error("early flag missed a pair change");
	drive_enable_a: assert property (oe_n_s |=> !rx_code_oe) // [RQ13]
		else $error("code pins driven while disabled");
	latch_start_a: assert property (latch_fall && !gen_rst_s |=> tone_enable
		&& gen_code_q == $past(tx_code_s)) // [RQ4]
		else $error("latch edge did not start generation");
	reset_silent_a: assert property (!tone_enable && !latch_fall |=> !tone_enable) // [RQ5]
		else $error("tones resumed without a new latch");
	code_d_tones_a: assert property (latch_fall && !gen_rst_s && tx_code_s == CODE_D
		|=> row_hz == 11'd941 && col_hz == 11'd1633) // [RQ7]
		else $error("wrong tone pair for code D");
endmodule

// [dtx_host.sv]
// host side model: drives the generator code, capture strobe and generator reset
`timescale 1ns/1ps
module dtx_host (
	// clock
	input wire logic ref_clk,
	// generator pins
	output logic [3:0] tx_code,
	output logic tx_latch,
	output logic tx_reset
);
	initial
	begin
		tx_code = 4'h0;
		tx_latch = 1'h0;
		tx_reset = 1'h0;
	end
	// code stays on the pins well past the strobe fall, the capture sees it synchronised
	task automatic dial(input logic [3:0] code);
		@(posedge ref_clk);
		tx_code <= code;
		tx_latch <= 1'h1;
		@(posedge ref_clk);
		tx_latch <= 1'h0;
		@(posedge ref_clk);
	endtask
	task automatic gen_reset(input logic v);
		@(posedge ref_clk);
		tx_reset <= v;
	endtask
endmodule

// [tb.sv]
// self-checking bench for the tone transceiver control block
`timescale 1ns/1ps
module tb;
	import dtx_pkg::*;
	// short tick keeps the 40 tick qualification quick
	localparam int SC = 4;
	typedef struct packed {logic [3:0] code; logic [1:0] r; logic [1:0] c;} dtx_row_s;
	localparam logic [3:0] KEYS [16] = '{4'h1, 4'h2, 4'h3, 4'hD, 4'h4, 4'h5, 4'h6, 4'hE,
		4'h7, 4'h8, 4'h9, 4'hF, 4'hB, 4'hA, 4'hC, 4'h0};
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic [3:0] row_tone = 4'h0;
	logic [3:0] col_tone = 4'h0;
	logic cp_energy = 1'h0;
	logic rx_output_enable_n = 1'h0;
	logic [3:0] rx_code;
	logic rx_code_oe;
	logic digit_valid;
	logic early_tone_flag;
	logic [3:0] tx_code;
	logic tx_latch;
	logic tx_reset;
	logic tone_enable;
	logic [10:0] row_hz;
	logic [10:0] col_hz;
	logic call_progress_out;
	logic hsel = 1'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic irq;
	logic [31:0] rd;
	int mismatches = 0;
	int num_checks = 0;
	dtx_row_s rows [16];

	always #20 ref_clk = ~ref_clk;

	dtx_host u_host (.ref_clk(ref_clk), .tx_code(tx_code), .tx_latch(tx_latch),
		.tx_reset(tx_reset));

	dtx_transceiver #(.SAMPLE_CYCLES(SC)) u_dut (.ref_clk(ref_clk), .rst(rst),
		.row_tone(row_tone), .col_tone(col_tone), .cp_energy(cp_energy),
		.rx_output_enable_n(rx_output_enable_n), .rx_code(rx_code), .rx_code_oe(rx_code_oe),
		.digit_valid(digit_valid), .early_tone_flag(early_tone_flag), .tx_code(tx_code),
		.tx_latch(tx_latch), .tx_reset(tx_reset), .tone_enable(tone_enable), .row_hz(row_hz),
		.col_hz(col_hz), .call_progress_out(call_progress_out), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one single word transfer, waits on hready in both phases
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
		hsel <= 1'h1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		htrans <= 2'h0;
		hsel <= 1'h0;
		hwdata <= wd;
		do @(posedge ref_clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask

	task automatic ticks(input int n);
		repeat (n * SC) @(posedge ref_clk);
	endtask

	task automatic pair(input logic [3:0] r, input logic [3:0] c, input int n);
		row_tone <= r;
		col_tone <= c;
		ticks(n);
	endtask

	task automatic cp(input logic v, input int n);
		cp_energy <= v;
		ticks(n);
	endtask

	initial
	begin
		repeat (50000) @(posedge ref_clk);
		mismatches++;
		finish_test();
	end

	initial
	begin
		for (int i = 0; i < 16; i++)
			rows[i] = {KEYS[i], 2'(i / 4), 2'(i % 4)};
		repeat (10) @(posedge ref_clk);
		rst <= 1'h0;
		@(posedge ref_clk);
		chk("tone_enable", tone_enable, 0);
		chk("digit_valid", digit_valid, 0);
		chk("hresp", hresp, 0);
		chk("hreadyout", hreadyout, 1);
		chk("early", early_tone_flag, 0);
		chk("row_hz", row_hz, 0);
		chk("cp_out", call_progress_out, 0);
		chk("irq", irq, 0);
		bus(1'h0, 32'(REG_CTRL), 32'h0000_0000);
		chk("ctrl", rd, 32'(CTRL_RST));
		$display("reset test done");
		for (int i = 0; i < 16; i++)
		begin
			u_host.dial(rows[i].code);
			repeat (6) @(posedge ref_clk);
			chk("tone_enable", tone_enable, 1);
			chk("row_hz", row_hz, ROW_HZ[rows[i].r]);
			chk("col_hz", col_hz, COL_HZ[rows[i].c]);
			pair(4'h1 << rows[i].r, 4'h1 << rows[i].c, 45);
			chk("rx_code", rx_code, rows[i].code);
			chk("digit_valid", digit_valid, 1);
			chk("rx_code_oe", rx_code_oe, 1);
			pair(4'h0, 4'h0, 45);
			chk("rx_code", rx_code, 0);
			chk("digit_valid", digit_valid, 0);
		end
		$display("digit table test done");
		pair(4'h2, 4'h4, 3);
		chk("early", early_tone_flag, 1);
		chk("digit_valid", digit_valid, 0);
		pair(4'h2, 4'h4, 42);
		chk("rx_code", rx_code, 4'h6);
		pair(4'h0, 4'h0, 3);
		chk("early", early_tone_flag, 0);
		chk("digit_valid", digit_valid, 1);
		pair(4'h0, 4'h0, 45);
		pair(4'h8, 4'h1, 20);
		pair(4'h0, 4'h0, 3);
		chk("digit_valid", digit_valid, 0);
		pair(4'h0, 4'h0, 42);
		pair(4'h8, 4'h1, 45);
		pair(4'h0, 4'h0, 20);
		pair(4'h8, 4'h1, 10);
		chk("digit_valid", digit_valid, 1);
		chk("rx_code", rx_code, KEYS[12]);
		rx_output_enable_n <= 1'h1;
		repeat (6) @(posedge ref_clk);
		chk("rx_code_oe", rx_code_oe, 0);
		rx_output_enable_n <= 1'h0;
		pair(4'h0, 4'h0, 45);
		$display("qualifier test done");
		cp(1'h1, 10);
		cp(1'h0, 3);
		chk("cp_out", call_progress_out, 0);
		cp(1'h0, 42);
		cp(1'h1, 45);
		chk("cp_out", call_progress_out, 1);
		cp(1'h0, 20);
		cp(1'h1, 10);
		chk("cp_out", call_progress_out, 1);
		cp(1'h0, 45);
		chk("cp_out", call_progress_out, 0);
		for (int k = 0; k < 2; k++)
		begin
			cp(1'h1, 100);
			chk("cp_out", call_progress_out, 1);
			cp(1'h0, 100);
			chk("cp_out", call_progress_out, 0);
		end
		$display("call progress test done");
		u_host.gen_reset(1'h1);
		repeat (6) @(posedge ref_clk);
		chk("tone_enable", tone_enable, 0);
		u_host.dial(4'h9);
		repeat (6) @(posedge ref_clk);
		chk("tone_enable", tone_enable, 0);
		u_host.gen_reset(1'h0);
		repeat (10) @(posedge ref_clk);
		chk("tone_enable", tone_enable, 0);
		u_host.dial(4'hC);
		repeat (6) @(posedge ref_clk);
		chk("tone_enable", tone_enable, 1);
		chk("col_hz", col_hz, COL_HZ[2]);
		$display("generator reset test done");
		// both detectors switched off: tones and energy must be ignored
		bus(1'h1, 32'(REG_CTRL), 32'h0000_0000);
		pair(4'h1, 4'h1, 0);
		cp(1'h1, 45);
		chk("digit_valid", digit_valid, 0);
		chk("early", early_tone_flag, 0);
		chk("cp_out", call_progress_out, 0);
		pair(4'h0, 4'h0, 0);
		cp(1'h0, 3);
		bus(1'h1, 32'(REG_CTRL), 32'(CTRL_RST));
		bus(1'h0, 32'(REG_STATUS), 32'h0000_0000);
		chk("status", rd, 32'h0000_0C80);
		$display("enable test done");
		chk("irq", irq, 0);
		bus(1'h0, 32'(REG_IRQ_STAT), 32'h0000_0000);
		chk("irq_stat", rd, 32'h0000_001F);
		bus(1'h1, 32'(REG_IRQ_MASK), 32'h0000_0001);
		repeat (3) @(posedge ref_clk);
		chk("irq", irq, 1);
		bus(1'h1, 32'(REG_IRQ_STAT), 32'h0000_001F);
		repeat (3) @(posedge ref_clk);
		chk("irq", irq, 0);
		bus(1'h0, 32'(REG_IRQ_STAT), 32'h0000_0000);
		chk("irq_stat", rd, 32'h0000_0000);
		bus(1'h0, 32'h0000_0040, 32'h0000_0000);
		chk("unmapped", rd, 32'h0000_0000);
		$display("register test done");
		finish_test();
	end
endmodule
